// >>> logic/lmr_decode.v
// Host request decoder: low memory top, remap window, Wishbone regs
//
// Functional notes
// [R1] Low top field bits 15:11 are address bits 31:27, 128 MB steps.
// [R2] Low top boundary address bits 26:0 compare as zero.
// [R3] Address at or above low top and below 4 GB is non-memory.
// [R4] Address below low top goes to DRAM, except legacy gap holes.
// [R5] Software must program low top to at least 0800h.
// [R6] Software should pick smaller of populated memory or I/O start.
// [R7] Low top register resets to 0800h.
// [R8] Base field bits 9:0 are address 35:26, base itself inside window.
// [R9] Base lower address bits 25:0 compare as zero, 64 MB aligned.
// [R10] Window is disabled while base exceeds limit.
// [R11] Base register resets to 03FFh, window disabled.
// [R12] Limit field is address 35:26, lower bits taken as all ones.
// [R13] Window hits are translated using the offset on bits 35:26.
// [R14] Reserved bits read zero and ignore writes.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`include "lmr_defs.vh"

module lmr_decode #(
	parameter WB_ADR_W = 12
) (
	// Clock and reset
	input  wire                  MCLK_IN,
	input  wire                  RST_IN,
	// Wishbone classic slave
	input  wire                  WB_CYC_IN,
	input  wire                  WB_STB_IN,
	input  wire                  WB_WE_IN,
	input  wire [WB_ADR_W-1:0]   WB_ADR_IN,
	input  wire [3:0]            WB_SEL_IN,
	input  wire [31:0]           WB_DAT_IN,
	output wire [31:0]           WB_DAT_OUT,
	output wire                  WB_ACK_OUT,
	// Host request
	input  wire                  REQ_VALID_IN,
	input  wire [35:0]           REQ_ADDR_IN,
	input  wire                  REQ_LEGACY_GAP_IN,
	// Decode result
	output wire                  DEC_VALID_OUT,
	output wire                  DEC_DRAM_OUT,
	output wire                  DEC_NONMEM_OUT,
	output wire                  DEC_REMAP_OUT,
	output wire                  DEC_GAP_OUT,
	output wire [35:0]           DEC_ADDR_OUT
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Byte-lane merge of a 16-bit register with a writable-bit mask
	function [15:0] lane_merge;
		input [15:0] old_val;
		input [15:0] wr_val;
		input [1:0]  sel;
		input [15:0] mask;
		reg   [15:0] tmp;
		begin
			tmp = old_val;
			if (sel[0]) begin
				tmp[7:0] = wr_val[7:0];
			end
			if (sel[1]) begin
				tmp[15:8] = wr_val[15:8];
			end
			lane_merge = tmp & mask;
		end
	endfunction

	// Hit counter: a hit in the clearing cycle is still counted
	function [15:0] bump;
		input [15:0] cnt;
		input        hit;
		input        clr;
		begin
			if (clr) begin
				bump = hit ? `LMR_CNT_ONE : `LMR_CNT_RST;
			end else if (hit) begin
				bump = cnt + `LMR_CNT_ONE;
			end else begin
				bump = cnt;
			end
		end
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [15:0]          low_top_reg;
	reg  [15:0]          rbase_reg;
	reg  [15:0]          rlimit_reg;
	reg  [15:0]          roffs_reg;
	reg  [15:0]          cnt_dram_reg;
	reg  [15:0]          cnt_nonmem_reg;
	reg  [15:0]          cnt_remap_reg;
	reg  [4:0]           status_reg;
	reg  [4:0]           status_next;
	reg                  ack_reg;
	reg  [31:0]          rdat_reg;
	reg  [31:0]          rdat_next;
	reg                  dec_valid_reg;
	reg                  dec_dram_reg;
	reg                  dec_nonmem_reg;
	reg                  dec_remap_reg;
	reg                  dec_gap_reg;
	reg  [35:0]          dec_addr_reg;
	reg                  dram_next;
	reg                  nonmem_next;
	reg                  remap_next;
	reg                  gap_next;
	reg  [35:0]          addr_next;
	wire [9:0]           wb_idx;
	wire                 wb_req;
	wire                 wb_wr;
	wire                 in_low_4g;
	wire                 below_top;
	wire                 win_en;
	wire                 win_hit;
	wire [9:0]           xlat_field;

	// ****************************************************************
	// Wishbone access decode
	// ****************************************************************
	// Word index is the byte address shifted by two
	assign wb_idx = WB_ADR_IN[`LMR_WB_IDX_HI:`LMR_WB_IDX_LO];
	assign wb_req = WB_CYC_IN & WB_STB_IN;
	// Writes land on the edge where ack is seen high by the master
	assign wb_wr  = wb_req & WB_WE_IN & ack_reg;

	// Read data is captured when ack is raised; unmapped reads give zero
	always @* begin
		rdat_next = 32'h0000_0000;
		case (wb_idx)
			`LMR_IDX_LOW_TOP: begin
				rdat_next[15:0] = low_top_reg;
			end
			`LMR_IDX_RBASE: begin
				rdat_next[15:0] = rbase_reg;
			end
			`LMR_IDX_RLIMIT: begin
				rdat_next[15:0] = rlimit_reg;
			end
			`LMR_IDX_ROFFS: begin
				rdat_next[15:0] = roffs_reg;
			end
			`LMR_IDX_STATUS: begin
				rdat_next[4:0] = status_reg;
			end
			`LMR_IDX_CNT_DRAM: begin
				rdat_next[15:0] = cnt_dram_reg;
			end
			`LMR_IDX_CNT_NONMEM: begin
				rdat_next[15:0] = cnt_nonmem_reg;
			end
			`LMR_IDX_CNT_REMAP: begin
				rdat_next[15:0] = cnt_remap_reg;
			end
			default: begin
				rdat_next = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			// One-cycle ack, dropped the cycle after it was given
			ack_reg <= wb_req & ~ack_reg;
			if (wb_req & ~ack_reg) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			low_top_reg <= `LMR_LOW_TOP_RST;                        // R7
			rbase_reg   <= `LMR_RBASE_RST;                          // R11
			rlimit_reg  <= `LMR_RLIMIT_RST;
			roffs_reg   <= `LMR_ROFFS_RST;
		end else if (wb_wr) begin
			// Masks keep reserved bits at zero
			if (wb_idx == `LMR_IDX_LOW_TOP) begin
				low_top_reg <= lane_merge(low_top_reg, WB_DAT_IN[15:0],
					WB_SEL_IN[1:0], `LMR_LOW_TOP_MASK);                // R14
			end
			if (wb_idx == `LMR_IDX_RBASE) begin
				rbase_reg <= lane_merge(rbase_reg, WB_DAT_IN[15:0],
					WB_SEL_IN[1:0], `LMR_WIN_MASK);                    // R14
			end
			if (wb_idx == `LMR_IDX_RLIMIT) begin
				rlimit_reg <= lane_merge(rlimit_reg, WB_DAT_IN[15:0],
					WB_SEL_IN[1:0], `LMR_WIN_MASK);                    // R14
			end
			if (wb_idx == `LMR_IDX_ROFFS) begin
				roffs_reg <= lane_merge(roffs_reg, WB_DAT_IN[15:0],
					WB_SEL_IN[1:0], `LMR_WIN_MASK);                    // R14
			end
		end
	end

	// ****************************************************************
	// Address classification
	// ****************************************************************
	// Low top compare looks at bits 31:27 only, so its lower bits are
	// zero by construction; no check guards a value below 0800h.
	assign in_low_4g = (REQ_ADDR_IN[`LMR_A_HI:`LMR_A_4G_LO] ==
		`LMR_A_ABOVE_4G_NONE);
	assign below_top = in_low_4g &
		(REQ_ADDR_IN[`LMR_A_LT_HI:`LMR_A_LT_LO] <
		low_top_reg[`LMR_LT_HI:`LMR_LT_LO]);                        // R1 R2

	lmr_window_cmp u_window (
		.addr_field_in  (REQ_ADDR_IN[`LMR_A_HI:`LMR_A_WIN_LO]),
		.base_field_in  (rbase_reg[`LMR_WIN_HI:`LMR_WIN_LO]),
		.limit_field_in (rlimit_reg[`LMR_WIN_HI:`LMR_WIN_LO]),
		.offs_field_in  (roffs_reg[`LMR_WIN_HI:`LMR_WIN_LO]),
		.win_en_out     (win_en),
		.win_hit_out    (win_hit),
		.xlat_field_out (xlat_field)
	);

	// Remap hit wins; above 4 GB outside the window goes to DRAM as is
	always @* begin
		dram_next   = 1'b0;
		nonmem_next = 1'b0;
		remap_next  = 1'b0;
		gap_next    = 1'b0;
		addr_next   = REQ_ADDR_IN;
		if (win_hit) begin
			dram_next  = 1'b1;
			remap_next = 1'b1;
			addr_next  = {xlat_field,
				REQ_ADDR_IN[`LMR_A_WIN_SUB_HI:0]};                    // R13
		end else if (in_low_4g & ~below_top) begin
			nonmem_next = 1'b1;                                      // R3
		end else if (below_top & REQ_LEGACY_GAP_IN) begin
			gap_next = 1'b1;                                         // R4
		end else begin
			dram_next = 1'b1;                                        // R4
		end
	end

	// ****************************************************************
	// Decode result registers
	// ****************************************************************
	always @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dec_valid_reg  <= 1'b0;
			dec_dram_reg   <= 1'b0;
			dec_nonmem_reg <= 1'b0;
			dec_remap_reg  <= 1'b0;
			dec_gap_reg    <= 1'b0;
			dec_addr_reg   <= 36'h0_0000_0000;
		end else begin
			dec_valid_reg <= REQ_VALID_IN;
			if (REQ_VALID_IN) begin
				dec_dram_reg   <= dram_next;
				dec_nonmem_reg <= nonmem_next;
				dec_remap_reg  <= remap_next;
				dec_gap_reg    <= gap_next;
				dec_addr_reg   <= addr_next;
			end else begin
				dec_dram_reg   <= 1'b0;
				dec_nonmem_reg <= 1'b0;
				dec_remap_reg  <= 1'b0;
				dec_gap_reg    <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Status and hit counters
	// ****************************************************************
	always @* begin
		status_next = status_reg;
		status_next[`LMR_ST_WIN_EN] = win_en;
		if (REQ_VALID_IN) begin
			status_next[`LMR_ST_DRAM]   = dram_next;
			status_next[`LMR_ST_NONMEM] = nonmem_next;
			status_next[`LMR_ST_REMAP]  = remap_next;
			status_next[`LMR_ST_GAP]    = gap_next;
		end
	end

	always @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			status_reg     <= 5'h00;
			cnt_dram_reg   <= `LMR_CNT_RST;
			cnt_nonmem_reg <= `LMR_CNT_RST;
			cnt_remap_reg  <= `LMR_CNT_RST;
		end else begin
			status_reg     <= status_next;
			// Any write to a counter clears it; counters wrap
			cnt_dram_reg   <= bump(cnt_dram_reg,
				REQ_VALID_IN & dram_next,
				wb_wr & (wb_idx == `LMR_IDX_CNT_DRAM));
			cnt_nonmem_reg <= bump(cnt_nonmem_reg,
				REQ_VALID_IN & nonmem_next,
				wb_wr & (wb_idx == `LMR_IDX_CNT_NONMEM));
			cnt_remap_reg  <= bump(cnt_remap_reg,
				REQ_VALID_IN & remap_next,
				wb_wr & (wb_idx == `LMR_IDX_CNT_REMAP));
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign WB_DAT_OUT     = rdat_reg;
	assign WB_ACK_OUT     = ack_reg;
	assign DEC_VALID_OUT  = dec_valid_reg;
	assign DEC_DRAM_OUT   = dec_dram_reg;
	assign DEC_NONMEM_OUT = dec_nonmem_reg;
	assign DEC_REMAP_OUT  = dec_remap_reg;
	assign DEC_GAP_OUT    = dec_gap_reg;
	assign DEC_ADDR_OUT   = dec_addr_reg;

endmodule // lmr_decode

// >>> logic/lmr_defs.vh
// Constants for the low memory top and remap window decoder
`ifndef LMR_DEFS_VH
`define LMR_DEFS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LMR_IDX_LOW_TOP     10'h0c4
`define LMR_IDX_RBASE       10'h0c6
`define LMR_IDX_RLIMIT      10'h0c8
`define LMR_IDX_ROFFS       10'h0ca
`define LMR_IDX_STATUS      10'h0d0
`define LMR_IDX_CNT_DRAM    10'h0d1
`define LMR_IDX_CNT_NONMEM  10'h0d2
`define LMR_IDX_CNT_REMAP   10'h0d3

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define LMR_LOW_TOP_RST     16'h0800
`define LMR_LOW_TOP_MASK    16'hf800
`define LMR_RBASE_RST       16'h03ff
`define LMR_RLIMIT_RST      16'h0000
`define LMR_ROFFS_RST       16'h0000
`define LMR_WIN_MASK        16'h03ff
`define LMR_CNT_RST         16'h0000
`define LMR_CNT_ONE         16'h0001

// ****************************************************************
// Register field positions
// ****************************************************************
`define LMR_LT_HI           15
`define LMR_LT_LO           11
`define LMR_WIN_HI          9
`define LMR_WIN_LO          0

// ****************************************************************
// Host address field positions
// ****************************************************************
`define LMR_A_HI            35
`define LMR_A_4G_LO         32
`define LMR_A_LT_HI         31
`define LMR_A_LT_LO         27
`define LMR_A_WIN_LO        26
`define LMR_A_WIN_SUB_HI    25
`define LMR_A_ABOVE_4G_NONE 4'h0

// ****************************************************************
// Status register bits
// ****************************************************************
`define LMR_ST_WIN_EN       0
`define LMR_ST_DRAM         1
`define LMR_ST_NONMEM       2
`define LMR_ST_REMAP        3
`define LMR_ST_GAP          4
`define LMR_ST_W            5

// ****************************************************************
// Bus widths
// ****************************************************************
`define LMR_REG_W           16
`define LMR_WB_DAT_W        32
`define LMR_WB_SEL_W        4
`define LMR_IDX_W           10
`define LMR_WB_IDX_HI       11
`define LMR_WB_IDX_LO       2

`endif

// >>> logic/lmr_window_cmp.v
// Remap window compare and address translation for one request
`timescale 1ns/10ps
`include "lmr_defs.vh"

module lmr_window_cmp (
	// Request address field, bits 35:26
	input  wire [9:0] addr_field_in,
	// Window setup fields
	input  wire [9:0] base_field_in,
	input  wire [9:0] limit_field_in,
	input  wire [9:0] offs_field_in,
	// Results
	output wire       win_en_out,
	output wire       win_hit_out,
	output wire [9:0] xlat_field_out
);

	// ****************************************************************
	// Window compare
	// ****************************************************************
	// Only the 64 MB granule is compared: the lower base bits act as
	// zeros and the lower limit bits as ones, so both ends are kept.
	wire base_ok;
	wire limit_ok;

	assign win_en_out     = (base_field_in <= limit_field_in);   // R10
	assign base_ok        = (addr_field_in >= base_field_in);    // R8 R9
	assign limit_ok       = (addr_field_in <= limit_field_in);   // R12
	assign win_hit_out    = win_en_out & base_ok & limit_ok;

	// ****************************************************************
	// Translation
	// ****************************************************************
	// Modulo subtraction; software keeps offset no larger than base.
	assign xlat_field_out = addr_field_in - offs_field_in;      // R13

endmodule // lmr_window_cmp

// >>> verif/lmr_decode_asserts.sv
// Port-level checks for the host request decoder
`timescale 1ns/10ps
module lmr_decode_asserts #(
	parameter WB_ADR_W = 12
) (
	// Clock and reset
	input wire                MCLK_IN,
	input wire                RST_IN,
	// Register bus
	input wire                WB_CYC_IN,
	input wire                WB_STB_IN,
	input wire                WB_WE_IN,
	input wire [WB_ADR_W-1:0] WB_ADR_IN,
	input wire [3:0]          WB_SEL_IN,
	input wire [31:0]         WB_DAT_IN,
	input wire [31:0]         WB_DAT_OUT,
	input wire                WB_ACK_OUT,
	// Host request and decode result
	input wire                REQ_VALID_IN,
	input wire [35:0]         REQ_ADDR_IN,
	input wire                REQ_LEGACY_GAP_IN,
	input wire                DEC_VALID_OUT,
	input wire                DEC_DRAM_OUT,
	input wire                DEC_NONMEM_OUT,
	input wire                DEC_REMAP_OUT,
	input wire                DEC_GAP_OUT,
	input wire [35:0]         DEC_ADDR_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);

	a_ack_pulse_only:
		assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held");
	a_ack_next_cycle:
		assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT)
			|=> WB_ACK_OUT)
		else $error("ack late");
	a_upper_read_zero:
		assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:16] == 16'h0000)
		else $error("upper read data set");
	a_dec_follows_req:
		assert property (REQ_VALID_IN |=> DEC_VALID_OUT)
		else $error("no result");
	a_flags_quiet:
		assert property (!DEC_VALID_OUT |-> !(DEC_DRAM_OUT
			|| DEC_NONMEM_OUT || DEC_REMAP_OUT || DEC_GAP_OUT))
		else $error("flag without valid");
	a_one_class:
		assert property (DEC_VALID_OUT |->
			$onehot({DEC_DRAM_OUT, DEC_NONMEM_OUT, DEC_GAP_OUT}))
		else $error("class not unique");
	a_remap_in_dram:
		assert property (DEC_REMAP_OUT |-> DEC_DRAM_OUT)
		else $error("remap not dram");
	a_above_4g_mem:
		assert property ((REQ_VALID_IN && REQ_ADDR_IN[35:32] != 4'h0)
			|=> !DEC_NONMEM_OUT && !DEC_GAP_OUT)
		else $error("above 4G not memory");
	a_low_bits_kept:
		assert property (REQ_VALID_IN |=>
			DEC_ADDR_OUT[25:0] == $past(REQ_ADDR_IN[25:0]))
		else $error("low address bits changed");
	a_plain_addr_kept:
		assert property ((DEC_VALID_OUT && !DEC_REMAP_OUT) |->
			DEC_ADDR_OUT == $past(REQ_ADDR_IN)) else $error("address changed");
	a_gap_needs_input:
		assert property (DEC_GAP_OUT |-> $past(REQ_LEGACY_GAP_IN))
		else $error("gap without gap input");
endmodule // lmr_decode_asserts

// >>> verif/lmr_decode_tb.sv
// Register and decode tests for the low memory top decoder
`timescale 1ns/10ps
`include "lmr_defs.vh"
module lmr_decode_tb;
	localparam logic [11:0] A_LT = {`LMR_IDX_LOW_TOP, 2'b00};
	localparam logic [11:0] A_RB = {`LMR_IDX_RBASE, 2'b00};
	localparam logic [11:0] A_RL = {`LMR_IDX_RLIMIT, 2'b00};
	localparam logic [11:0] A_RO = {`LMR_IDX_ROFFS, 2'b00};
	localparam logic [11:0] A_ST = {`LMR_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_CD = {`LMR_IDX_CNT_DRAM, 2'b00};
	localparam logic [11:0] A_CN = {`LMR_IDX_CNT_NONMEM, 2'b00};
	localparam logic [11:0] A_CR = {`LMR_IDX_CNT_REMAP, 2'b00};
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	wire  [31:0] wb_dat;
	wire         wb_ack;
	wire         rv;
	wire         rg;
	wire  [35:0] ra;
	wire  [35:0] da;
	wire  [4:0]  dfl;
	integer      err_total = 0;
	integer      checked = 0;
	integer      cycles = 0;

	always #2 mclk_in = ~mclk_in;

	lmr_host_model host (.clk_in(mclk_in), .req_valid_out(rv),
		.req_addr_out(ra), .req_gap_out(rg));
	lmr_decode dut (.MCLK_IN(mclk_in), .RST_IN(rst_in), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(wdat), .WB_DAT_OUT(wb_dat), .WB_ACK_OUT(wb_ack),
		.REQ_VALID_IN(rv), .REQ_ADDR_IN(ra), .REQ_LEGACY_GAP_IN(rg),
		.DEC_VALID_OUT(dfl[4]), .DEC_DRAM_OUT(dfl[3]),
		.DEC_NONMEM_OUT(dfl[2]), .DEC_REMAP_OUT(dfl[1]),
		.DEC_GAP_OUT(dfl[0]), .DEC_ADDR_OUT(da));

	// ****************************************
	// Shared tasks
	// ****************************************
	task give_verdict;
		if (err_total == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input string nm, input logic [35:0] s, input logic [35:0] e);
		checked = checked + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wb_go(input logic [11:0] a, input logic w, input logic [15:0] d);
		integer n;
		@(posedge mclk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge mclk_in);
			n = n + 1;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
			err_total = err_total + 1;
		rdat = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wb_rd(input logic [11:0] a, input logic [15:0] e);
		wb_go(a, 1'b0, 16'h0000);
		check("read data", {4'h0, rdat}, {20'h0_0000, e});
	endtask
	// Flags are valid, dram, nonmem, remap, gap
	task req(input logic [35:0] a, input logic g, input logic [3:0] f,
		input logic [35:0] x);
		host.issue(a, g);
		#1;
		check("decode flags", {31'h0, dfl}, {31'h0, 1'b1, f});
		check("decode addr", da, x);
	endtask

	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		wb_rd(A_LT, 16'h0800);
		wb_rd(A_RB, 16'h03ff);
		wb_rd(12'hffc, 16'h0000);
		wb_rd(A_ST, 16'h0000);
		wb_go(A_LT, 1'b1, 16'hffff);
		wb_rd(A_LT, 16'hf800);
		wb_go(A_RB, 1'b1, 16'hffff);
		wb_rd(A_RB, 16'h03ff);
		req(36'hf_fc00_0000, 1'b0, 4'b1000, 36'hf_fc00_0000);
		wb_go(A_LT, 1'b1, 16'hc000);
		req(36'h0_bfff_ffff, 1'b0, 4'b1000, 36'h0_bfff_ffff);
		req(36'h0_c000_0000, 1'b0, 4'b0100, 36'h0_c000_0000);
		req(36'h0_ffff_ffff, 1'b0, 4'b0100, 36'h0_ffff_ffff);
		req(36'h0_c000_0000, 1'b1, 4'b0100, 36'h0_c000_0000);
		req(36'h0_0000_1000, 1'b1, 4'b0001, 36'h0_0000_1000);
		wb_go(A_RB, 1'b1, 16'h0040);
		wb_go(A_RL, 1'b1, 16'h0043);
		wb_go(A_RO, 1'b1, 16'h0010);
		wb_rd(A_RL, 16'h0043);
		wb_rd(A_RO, 16'h0010);
		wb_rd(A_ST, 16'h0011);
		req(36'h1_0000_0000, 1'b0, 4'b1010, 36'h0_c000_0000);
		req(36'h1_0fff_ffff, 1'b0, 4'b1010, 36'h0_cfff_ffff);
		req(36'h1_1000_0000, 1'b0, 4'b1000, 36'h1_1000_0000);
		req(36'h0_ffff_ffff, 1'b0, 4'b0100, 36'h0_ffff_ffff);
		wb_go(A_RB, 1'b1, 16'h0044);
		req(36'h1_0c00_0000, 1'b0, 4'b1000, 36'h1_0c00_0000);
		wb_rd(A_ST, 16'h0002);
		// Hit counts of every dram, nonmem and remap request issued above, then a clear
		wb_rd(A_CD, 16'h0006);
		wb_rd(A_CN, 16'h0004);
		wb_rd(A_CR, 16'h0002);
		wb_go(A_CD, 1'b1, 16'h0000);
		wb_rd(A_CD, 16'h0000);
		give_verdict;
	end
endmodule // lmr_decode_tb

bind lmr_decode lmr_decode_asserts #(.WB_ADR_W(WB_ADR_W)) u_chk (.*);

// >>> verif/lmr_host_model.sv
// Host bus model issuing one-cycle memory requests
`timescale 1ns/10ps
module lmr_host_model (
	// Clock
	input  wire         clk_in,
	// Request
	output logic        req_valid_out,
	output logic [35:0] req_addr_out,
	output logic        req_gap_out
);
	initial begin
		req_valid_out = 1'b0;
		req_addr_out = 36'h0_0000_0000;
		req_gap_out = 1'b0;
	end
	// Idle lines show the inverse so a stale address never looks valid
	task issue(input logic [35:0] a, input logic g);
		@(posedge clk_in);
		req_valid_out <= 1'b1;
		req_addr_out <= a;
		req_gap_out <= g;
		@(posedge clk_in);
		req_valid_out <= 1'b0;
		req_addr_out <= ~a;
		req_gap_out <= ~g;
	endtask
endmodule // lmr_host_model
